// *** design/dsf_formatter.sv ***
// Purpose: build and parse the disk-information sector header
// Assumes: field inputs stay stable while a sector is being built
// Notes:   bytes past the header come through from the tail stream
// Notes on behaviour
// - sector is exactly 8192 bytes, fixed offsets
// - bytes 0 and 1 both carry identifier
// - nine serial digits, two per byte
// - byte 6 low nibble marks side
// - same serial on both sides
// - byte 7 carries revision number
// - bytes 8 to 15 carry maker code
// - byte 16 is year minus 2000
// - byte 17 is month 1 to 12
// - byte 18 is day 1 to 31
// - bytes 19 to 22 recorder serial, msb first
// - byte 23 media kind 0 or 1
// - bytes 24-25 capacity fixed value
// - byte 26 sector size over 1024
// - byte 27 track pitch by media kind
// - byte 28 wavelength code fixed
// - byte 29 lens aperture code fixed
// - bytes 30-31 refractive index, msb first
// - byte 32 cover thickness in nm

`timescale 1ns/1ps

module dsf_formatter
	import dsf_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [7:0]        reg_rdata_o,
	// header field values for the formatter
	input  wire logic [35:0]       disk_serial_i,
	input  wire logic [63:0]       maker_code_i,
	input  wire logic [11:0]       mfg_year_i,
	input  wire logic [7:0]        mfg_month_i,
	input  wire logic [7:0]        mfg_day_i,
	input  wire logic [31:0]       recorder_unit_serial_i,
	input  wire logic [15:0]       cover_index_i,
	input  wire logic [7:0]        cover_thick_i,
	// tail bytes 33 onward
	input  wire logic [7:0]        tail_data_i,
	input  wire logic              tail_valid_i,
	output logic                   tail_ready_o,
	// outgoing sector stream
	output logic      [7:0]        tx_data_o,
	output logic                   tx_valid_o,
	output logic                   tx_last_o,
	input  wire logic              tx_ready_i,
	// incoming sector stream
	input  wire logic [7:0]        rx_data_i,
	input  wire logic              rx_valid_i,
	input  wire logic              rx_last_i,
	// parsed results
	output logic                   rx_done_o,
	output logic                   hdr_valid_o,
	output logic      [35:0]       rx_serial_o,
	output logic      [3:0]        rx_side_o,
	output logic                   rx_write_once_media_o,
	output logic      [31:0]       rx_recorder_unit_serial_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		dsf_fmt_e    fst;      // formatter phase
		logic [12:0] fcnt;     // next byte index to emit
		logic        ovld;     // output byte held
		logic [7:0]  odat;     // output byte
		logic        olast;    // output byte is the final one
		logic [12:0] rcnt;     // next byte index expected on rx
		logic        rbusy;    // rx sector in progress
		logic        rdone;    // sticky: a sector was parsed
		logic        rinv;     // sticky: sector rejected
		logic        rlen;     // sticky: length wrong
		logic        rrange;   // sticky: field out of range
		logic        rpulse;   // one-cycle end of sector
		logic        ctl_wo;   // build write-once media header
		logic        ctl_sideb;// build side B header
		logic [7:0]  rev;      // revision byte
		logic [35:0] rserial;  // parsed serial digits
		logic [3:0]  rside;    // parsed side nibble
		logic        rwo;      // parsed media kind
		logic [31:0] rrec;     // parsed recorder serial
		logic [7:0]  rdreg;    // register read data
		logic        rdsel;    // read came from the header store
	} dsf_state_s;

	dsf_state_s           cur_ff;     // registered state
	dsf_state_s           nxt_ff;     // next state
	logic                 load;       // formatter takes the next byte
	logic [HDR_W-1:0]     hdr_image;  // header bytes 0..32, byte 0 on top
	logic [7:0]           ram_q;      // header store read data
	logic                 ram_we;     // parser writes header store

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// range test shared by month and day checks
	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// pick header byte idx from the packed image
	function automatic logic [7:0] hdr_pick(input logic [HDR_W-1:0] img,
		input logic [12:0] idx);
		logic [5:0] sh;
		sh       = 6'(HDR_LAST - idx);
		hdr_pick = img[{sh, 3'h0} +: 8];
	endfunction : hdr_pick

	// ------------------------------------------------------------
	// header image, byte 0 in the top bits
	// ------------------------------------------------------------
	// the serial digits never depend on the side bit, so A and B match
	always_comb begin
		hdr_image = {
			ID_BYTE, ID_BYTE,
			disk_serial_i,
			(cur_ff.ctl_sideb ? SIDE_B : SIDE_A),
			cur_ff.rev,
			maker_code_i,
			8'(mfg_year_i - YEAR_BASE),
			mfg_month_i,
			mfg_day_i,
			recorder_unit_serial_i,
			(cur_ff.ctl_wo ? MEDIA_WO : MEDIA_RW),
			CAP_GB,
			SECSZ_VAL,
			(cur_ff.ctl_wo ? PITCH_WO : PITCH_RW),
			WAVE_VAL,
			APERT_VAL,
			cover_index_i,
			cover_thick_i
		};
	end

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	// a byte moves in when the holding stage is empty or draining
	assign load = (cur_ff.fst != FMT_IDLE) && (!cur_ff.ovld || tx_ready_i) &&
		((cur_ff.fst == FMT_HEAD) || tail_valid_i);
	// tail stream stalls with the channel, no buffer between them
	assign tail_ready_o = (cur_ff.fst == FMT_TAIL) && (!cur_ff.ovld || tx_ready_i);
	assign ram_we       = rx_valid_i && (cur_ff.rcnt <= HDR_LAST);

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt_ff        = cur_ff;
		nxt_ff.rpulse = 1'b0;

		// register writes; config only changes between sectors
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CTRL: begin
					if (cur_ff.fst == FMT_IDLE && !cur_ff.ovld) begin
						nxt_ff.ctl_wo    = reg_wdata_i[CTRL_WO];
						nxt_ff.ctl_sideb = reg_wdata_i[CTRL_SIDEB];
						if (reg_wdata_i[CTRL_START]) begin
							nxt_ff.fst  = FMT_HEAD;
							nxt_ff.fcnt = OFS_ID0;
						end
					end
				end
				REG_STATUS: begin
					// write one to clear; parser sets below win
					if (reg_wdata_i[STS_DONE])  nxt_ff.rdone  = 1'b0;
					if (reg_wdata_i[STS_INV])   nxt_ff.rinv   = 1'b0;
					if (reg_wdata_i[STS_LEN])   nxt_ff.rlen   = 1'b0;
					if (reg_wdata_i[STS_RANGE]) nxt_ff.rrange = 1'b0;
				end
				REG_REV: begin
					if (cur_ff.fst == FMT_IDLE) nxt_ff.rev = reg_wdata_i;
				end
				default: begin
					// unmapped write ignored
				end
			endcase
		end

		// formatter: header from image, tail passed through
		if (load) begin
			nxt_ff.ovld  = 1'b1;
			nxt_ff.odat  = (cur_ff.fst == FMT_HEAD) ? hdr_pick(hdr_image, cur_ff.fcnt)
				: tail_data_i;
			nxt_ff.olast = (cur_ff.fcnt == LAST_IDX);
			nxt_ff.fcnt  = cur_ff.fcnt + 13'h0001;
			if (cur_ff.fcnt == HDR_LAST) begin
				nxt_ff.fst = FMT_TAIL;
			end
			if (cur_ff.fcnt == LAST_IDX) begin
				nxt_ff.fst  = FMT_IDLE;
				nxt_ff.fcnt = OFS_ID0;
			end
		end else if (tx_ready_i) begin
			nxt_ff.ovld = 1'b0;
		end

		// parser: one byte per valid, never stalled
		if (rx_valid_i) begin
			nxt_ff.rbusy = 1'b1;
			if (cur_ff.rcnt == OFS_ID0) begin
				// fresh sector drops the previous verdict
				nxt_ff.rdone  = 1'b0;
				nxt_ff.rinv   = 1'b0;
				nxt_ff.rlen   = 1'b0;
				nxt_ff.rrange = 1'b0;
			end
			case (cur_ff.rcnt)
				OFS_ID0, OFS_ID1: begin
					if (rx_data_i != ID_BYTE) nxt_ff.rinv = 1'b1;
				end
				OFS_SIDE: begin
					nxt_ff.rserial = {cur_ff.rserial[31:0], rx_data_i[7:4]};
					nxt_ff.rside   = rx_data_i[3:0];
					if (rx_data_i[3:0] != SIDE_A && rx_data_i[3:0] != SIDE_B) begin
						nxt_ff.rrange = 1'b1;
					end
				end
				OFS_MONTH: begin
					if (!in_range(rx_data_i, MONTH_MIN, MONTH_MAX)) nxt_ff.rrange = 1'b1;
				end
				OFS_DAY: begin
					if (!in_range(rx_data_i, DAY_MIN, DAY_MAX)) nxt_ff.rrange = 1'b1;
				end
				OFS_MEDIA: begin
					nxt_ff.rwo = (rx_data_i == MEDIA_WO);
					if (rx_data_i != MEDIA_WO && rx_data_i != MEDIA_RW) nxt_ff.rrange = 1'b1;
				end
				default: begin
					// serial pairs and recorder serial shift in msb first
					if (cur_ff.rcnt >= OFS_SERIAL && cur_ff.rcnt < OFS_SIDE) begin
						nxt_ff.rserial = {cur_ff.rserial[27:0], rx_data_i};
					end
					if (cur_ff.rcnt >= OFS_REC && cur_ff.rcnt <= OFS_REC_END) begin
						nxt_ff.rrec = {cur_ff.rrec[23:0], rx_data_i};
					end
				end
			endcase
			// end of sector by marker or by count, both must agree
			if (rx_last_i || cur_ff.rcnt == LAST_IDX) begin
				if (rx_last_i != (cur_ff.rcnt == LAST_IDX)) begin
					nxt_ff.rlen = 1'b1;
					nxt_ff.rinv = 1'b1;
				end
				nxt_ff.rcnt   = OFS_ID0;
				nxt_ff.rbusy  = 1'b0;
				nxt_ff.rdone  = 1'b1;
				nxt_ff.rpulse = 1'b1;
			end else begin
				nxt_ff.rcnt = cur_ff.rcnt + 13'h0001;
			end
		end

		// register reads, answered one cycle later
		nxt_ff.rdsel = 1'b0;
		nxt_ff.rdreg = 8'h00;
		if (reg_rd_i) begin
			if (reg_addr_i >= HDR_BASE && reg_addr_i <= HDR_TOP) begin
				nxt_ff.rdsel = 1'b1;
			end else begin
				case (reg_addr_i)
					REG_CTRL: begin
						nxt_ff.rdreg[CTRL_WO]    = cur_ff.ctl_wo;
						nxt_ff.rdreg[CTRL_SIDEB] = cur_ff.ctl_sideb;
					end
					REG_STATUS: begin
						nxt_ff.rdreg[STS_FBUSY] = (cur_ff.fst != FMT_IDLE) || cur_ff.ovld;
						nxt_ff.rdreg[STS_DONE]  = cur_ff.rdone;
						nxt_ff.rdreg[STS_INV]   = cur_ff.rinv;
						nxt_ff.rdreg[STS_LEN]   = cur_ff.rlen;
						nxt_ff.rdreg[STS_RANGE] = cur_ff.rrange;
						nxt_ff.rdreg[STS_RBUSY] = cur_ff.rbusy;
					end
					REG_REV:  nxt_ff.rdreg = cur_ff.rev;
					default:  nxt_ff.rdreg = 8'h00;                    // unmapped reads zero
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			cur_ff     <= '0;
			cur_ff.fst <= FMT_IDLE;
			cur_ff.rev <= REV_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ------------------------------------------------------------
	// parsed header store
	// ------------------------------------------------------------
	dsf_hdr_ram u_hdr_ram (
		.clock_i   (clock_i),
		.resetn_i  (resetn_i),
		.wr_en_i   (ram_we),
		.wr_addr_i (cur_ff.rcnt[RAM_AW-1:0]),
		.wr_data_i (rx_data_i),
		.rd_en_i   (reg_rd_i),
		.rd_addr_i (6'(reg_addr_i - HDR_BASE)),
		.rd_data_o (ram_q)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_o  = cur_ff.rdsel ? ram_q : cur_ff.rdreg;
	assign tx_data_o    = cur_ff.odat;
	assign tx_valid_o   = cur_ff.ovld;
	assign tx_last_o    = cur_ff.olast && cur_ff.ovld;
	assign rx_done_o    = cur_ff.rpulse;
	// rejected or half-received sectors never look valid
	assign hdr_valid_o  = cur_ff.rdone && !cur_ff.rinv && !cur_ff.rbusy;
	assign rx_serial_o  = cur_ff.rserial;
	assign rx_side_o    = cur_ff.rside;
	assign rx_write_once_media_o     = cur_ff.rwo;
	assign rx_recorder_unit_serial_o = cur_ff.rrec;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_load_at(logic [12:0] idx);
		load && (cur_ff.fcnt == idx);
	endsequence

	sequence s_rx_at(logic [12:0] idx);
		rx_valid_i && (cur_ff.rcnt == idx);
	endsequence

	a_tx_id_bytes: assert property (s_load_at(OFS_ID1) |=> tx_valid_o && tx_data_o == ID_BYTE)
		else $error("identifier byte wrong");
	a_tx_side_nib: assert property (s_load_at(OFS_SIDE) |=> tx_data_o[3:0] ==
		($past(cur_ff.ctl_sideb) ? SIDE_B : SIDE_A))
		else $error("side nibble wrong");
	a_tx_pitch_kind: assert property (s_load_at(OFS_PITCH) |=> tx_data_o ==
		($past(cur_ff.ctl_wo) ? PITCH_WO : PITCH_RW))
		else $error("track pitch byte wrong");
	a_tx_cap_word: assert property (s_load_at(OFS_CAP) |=> tx_data_o == CAP_GB[15:8])
		else $error("capacity high byte wrong");
	a_tx_year_code: assert property (s_load_at(OFS_YEAR) |=>
		tx_data_o == 8'($past(mfg_year_i) - YEAR_BASE))
		else $error("year byte wrong");
	a_tx_frame_end: assert property (s_load_at(LAST_IDX) |=> tx_last_o ##1
		(cur_ff.fst == FMT_IDLE))
		else $error("sector end misplaced");
	a_tx_hold_data: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
		$stable(tx_data_o))
		else $error("output byte dropped under stall");
	a_rx_bad_id: assert property (s_rx_at(OFS_ID1) ##0 (rx_data_i != ID_BYTE) |=>
		cur_ff.rinv)
		else $error("bad identifier not flagged");
	a_rx_no_valid: assert property (cur_ff.rinv |-> !hdr_valid_o)
		else $error("rejected sector reported valid");
	a_rx_short_len: assert property (rx_valid_i && rx_last_i && cur_ff.rcnt != LAST_IDX
		|=> cur_ff.rlen && rx_done_o && !hdr_valid_o)
		else $error("short sector accepted");

endmodule : dsf_formatter

// *** design/dsf_pkg.sv ***
// Purpose: shared constants and types of the disk-information sector formatter
// Assumes: byte-wide sector stream, sector index counted from zero
// Notes:   every offset, field value and register address lives here

package dsf_pkg;

	// ------------------------------------------------------------
	// sector geometry
	// ------------------------------------------------------------
	localparam int          SECTOR_LEN = 8192;              // bytes per sector
	localparam int          IDX_W      = 13;                // sector byte index width
	localparam logic [12:0] LAST_IDX   = 13'(SECTOR_LEN - 1);
	localparam int          HDR_LEN    = 33;                // bytes 0..32 built here
	localparam logic [12:0] HDR_LAST   = 13'(HDR_LEN - 1);
	localparam int          HDR_W      = HDR_LEN * 8;       // header image bits

	// ------------------------------------------------------------
	// byte offsets inside the sector
	// ------------------------------------------------------------
	localparam logic [12:0] OFS_ID0     = 13'h0000;
	localparam logic [12:0] OFS_ID1     = 13'h0001;
	localparam logic [12:0] OFS_SERIAL  = 13'h0002;         // first packed digit pair
	localparam logic [12:0] OFS_SIDE    = 13'h0006;         // ninth digit plus side
	localparam logic [12:0] OFS_REV     = 13'h0007;
	localparam logic [12:0] OFS_MAKER   = 13'h0008;
	localparam logic [12:0] OFS_YEAR    = 13'h0010;
	localparam logic [12:0] OFS_MONTH   = 13'h0011;
	localparam logic [12:0] OFS_DAY     = 13'h0012;
	localparam logic [12:0] OFS_REC     = 13'h0013;         // recorder serial msb
	localparam logic [12:0] OFS_REC_END = 13'h0016;         // recorder serial lsb
	localparam logic [12:0] OFS_MEDIA   = 13'h0017;
	localparam logic [12:0] OFS_CAP     = 13'h0018;
	localparam logic [12:0] OFS_CAP_LO  = 13'h0019;
	localparam logic [12:0] OFS_SECSZ   = 13'h001a;
	localparam logic [12:0] OFS_PITCH   = 13'h001b;
	localparam logic [12:0] OFS_WAVE    = 13'h001c;
	localparam logic [12:0] OFS_APERT   = 13'h001d;
	localparam logic [12:0] OFS_REFR    = 13'h001e;
	localparam logic [12:0] OFS_THICK   = 13'h0020;

	// ------------------------------------------------------------
	// field values
	// ------------------------------------------------------------
	localparam logic [7:0]  ID_BYTE    = 8'hd1;
	localparam logic [3:0]  SIDE_A     = 4'ha;
	localparam logic [3:0]  SIDE_B     = 4'hb;
	localparam logic [11:0] YEAR_BASE  = 12'h7d0;           // calendar year 2000
	localparam logic [7:0]  MONTH_MIN  = 8'h01;
	localparam logic [7:0]  MONTH_MAX  = 8'h0c;
	localparam logic [7:0]  DAY_MIN    = 8'h01;
	localparam logic [7:0]  DAY_MAX    = 8'h1f;
	localparam logic [7:0]  MEDIA_RW   = 8'h00;
	localparam logic [7:0]  MEDIA_WO   = 8'h01;
	localparam logic [15:0] CAP_GB     = 16'h001e;
	localparam logic [7:0]  SECSZ_VAL  = 8'h08;             // sector size / 1024
	localparam logic [7:0]  PITCH_RW   = 8'h50;             // 80
	localparam logic [7:0]  PITCH_WO   = 8'h4a;             // 74
	localparam logic [7:0]  WAVE_VAL   = 8'h51;             // 81
	localparam logic [7:0]  APERT_VAL  = 8'h46;             // 70

	// ------------------------------------------------------------
	// register port map
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h01;
	localparam logic [7:0]  REG_REV    = 8'h02;
	localparam logic [7:0]  HDR_BASE   = 8'h40;             // parsed header bytes
	localparam logic [7:0]  HDR_TOP    = 8'h60;             // last header byte address
	localparam int          CTRL_START = 0;
	localparam int          CTRL_WO    = 1;
	localparam int          CTRL_SIDEB = 2;
	localparam int          STS_FBUSY  = 0;
	localparam int          STS_DONE   = 1;
	localparam int          STS_INV    = 2;
	localparam int          STS_LEN    = 3;
	localparam int          STS_RANGE  = 4;
	localparam int          STS_RBUSY  = 5;
	localparam logic [7:0]  REV_RESET  = 8'h00;
	localparam int          RAM_AW     = 6;

	// ------------------------------------------------------------
	// formatter sequencing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_IDLE,
		FMT_HEAD,
		FMT_TAIL
	} dsf_fmt_e;

endpackage : dsf_pkg

// *** design/dsf_hdr_ram.sv ***
// Purpose: small store for the parsed header bytes
// Assumes: one write port from the parser, one read port from software
// Notes:   read data come out of a register one cycle after the read

`timescale 1ns/1ps

module dsf_hdr_ram
	import dsf_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// write side
	input  wire logic              wr_en_i,
	input  wire logic [RAM_AW-1:0] wr_addr_i,
	input  wire logic [7:0]        wr_data_i,
	// read side
	input  wire logic              rd_en_i,
	input  wire logic [RAM_AW-1:0] rd_addr_i,
	output logic      [7:0]        rd_data_o
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] mem [0:(1<<RAM_AW)-1];   // header byte array
	logic [7:0] rd_q_ff;                 // registered read data

	// array has no reset: only read data must be defined
	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// read register, cleared by reset
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rd_q_ff <= 8'h00;
		end else if (rd_en_i) begin
			rd_q_ff <= mem[rd_addr_i];
		end
	end

	assign rd_data_o = rd_q_ff;

endmodule : dsf_hdr_ram

// *** tb/dsf_chan_model.sv ***
// Purpose: sector channel beside the formatter, records and replays a sector
// Assumes: one sector in flight at a time
// Notes:   slow mode stalls every other cycle to exercise tx holding

`timescale 1ns/1ps

module dsf_chan_model (
	// clock and control from bench
	input  wire logic       clock_i,
	input  wire logic       slow_i,
	input  wire logic       replay_i,
	input  wire logic       bad_i,
	input  wire logic       cut_i,
	// write channel
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	// read channel
	output logic      [7:0] rx_data_o,
	output logic            rx_valid_o,
	output logic            rx_last_o
);
	logic [7:0]  mem [0:8191];  // captured sector image
	logic [12:0] wp      = '0;  // wraps to zero after a whole sector
	logic [12:0] last_at = '0;  // index that carried the last marker
	int          nsec    = 0;   // sectors fully received
	int          rp      = -1;  // replay index, idle below zero
	logic        ph      = 1'b0;
	initial begin
		tx_ready_o = 1'b0;
		rx_data_o  = 8'h00;
		rx_valid_o = 1'b0;
		rx_last_o  = 1'b0;
	end
	// capture, stall and replay in one process
	always @(posedge clock_i) begin
		ph         <= ~ph;
		tx_ready_o <= slow_i ? ph : 1'b1;
		if (tx_valid_i && tx_ready_o) begin
			mem[wp] <= tx_data_i;
			wp      <= wp + 13'h0001;
			if (tx_last_i) begin
				last_at <= wp;
				nsec    <= nsec + 1;
			end
		end
		if (replay_i) rp = 0;
		if (rp >= 0) begin
			rx_valid_o <= 1'b1;
			rx_data_o  <= (bad_i && rp == 1) ? 8'hd0 : mem[rp];
			// a cut sector ends at half length with the marker
			rx_last_o  <= (rp == 8191) || (cut_i && rp == 4095);
			rp          = (rp == 8191 || (cut_i && rp == 4095)) ? -1 : rp + 1;
		end else begin
			// idle line is not held at the last value
			rx_valid_o <= 1'b0;
			rx_last_o  <= 1'b0;
			rx_data_o  <= ~rx_data_o;
		end
	end
endmodule : dsf_chan_model

// *** tb/disk_info_sector_formatter_bench.sv ***
// Purpose: self-checking bench of the sector formatter and parser
// Assumes: channel model loops the written sector back on request
// Notes:   tail bytes count up from zero at byte 33

`timescale 1ns/1ps

module disk_info_sector_formatter_bench;
	import dsf_pkg::*;
	logic clock_i = 1'b0, resetn_i = 1'b0;
	logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, tail_data_i = '0, reg_rdata_o, tx_data_o, rx_data_i;
	logic reg_wr_i = 0, reg_rd_i = 0, tail_valid_i = 1, slow = 0, replay = 0, bad = 0, cut = 0;
	logic tail_ready_o, tx_valid_o, tx_last_o, tx_ready_i, rx_valid_i, rx_last_i;
	logic rx_done_o, hdr_valid_o, rx_wo_o;
	logic [35:0] rx_serial_o;
	logic [3:0]  rx_side_o;
	logic [31:0] rx_rec_o;
	int mismatches = 0, n_checks = 0, cyc = 0;
	localparam logic [35:0] SER = 36'h123456789;
	localparam logic [63:0] MKR = "DSKMAKER";
	localparam logic [31:0] REC = 32'h89abcdef;
	always #25 clock_i = ~clock_i;
	always @(posedge clock_i) if (tail_valid_i && tail_ready_o) tail_data_i <= tail_data_i + 8'h01;
	dsf_formatter dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .disk_serial_i(SER), .maker_code_i(MKR),
		.mfg_year_i(12'h7e9), .mfg_month_i(8'h0c), .mfg_day_i(8'h1f),
		.recorder_unit_serial_i(REC), .cover_index_i(16'h3b10), .cover_thick_i(8'h64),
		.tail_data_i(tail_data_i), .tail_valid_i(tail_valid_i), .tail_ready_o(tail_ready_o),
		.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
		.tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
		.rx_last_i(rx_last_i), .rx_done_o(rx_done_o), .hdr_valid_o(hdr_valid_o),
		.rx_serial_o(rx_serial_o), .rx_side_o(rx_side_o),
		.rx_write_once_media_o(rx_wo_o), .rx_recorder_unit_serial_o(rx_rec_o));
	dsf_chan_model ch_u (.clock_i(clock_i), .slow_i(slow), .replay_i(replay), .bad_i(bad),
		.cut_i(cut), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o),
		.tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
		.rx_last_o(rx_last_i));
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
		@(posedge clock_i) reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clock_i) reg_rd_i <= 1'b0;
		@(negedge clock_i) d = reg_rdata_o;
	endtask : rd
	// format one sector, then compare every header byte and the tail ends
	task automatic fmt_sector(input logic wo, input logic sb);
		logic [263:0] e;
		logic [7:0] d;
		int n;
		n = ch_u.nsec;
		@(posedge clock_i) tail_data_i <= 8'h00;
		wr(REG_CTRL, {5'h00, sb, wo, 1'b1});
		// both writes land while busy and must be ignored
		wr(REG_REV, 8'h33);
		wr(REG_CTRL, {5'h00, !sb, !wo, 1'b1});
		for (int k = 0; k < 40000 && ch_u.nsec == n; k++) @(posedge clock_i);
		@(negedge clock_i);
		chk("sector sent", 64'(n + 1), 64'(ch_u.nsec));
		e = {16'hd1d1, SER[35:4], SER[3:0], sb ? 4'hb : 4'ha, 8'h5a, MKR, 8'h19, 8'h0c, 8'h1f,
			REC, 7'h00, wo, 16'h001e, 8'h08, wo ? 8'h4a : 8'h50, 8'h51, 8'h46, 16'h3b10, 8'h64};
		for (int k = 0; k < 33; k++)
			chk($sformatf("byte %0d", k), 64'(e[263-8*k -: 8]), 64'(ch_u.mem[k]));
		chk("byte 33", 64'h00, 64'(ch_u.mem[33]));
		chk("byte 8191", 64'hde, 64'(ch_u.mem[8191]));
		chk("last index", 64'h1fff, 64'(ch_u.last_at));
		chk("length wrap", 64'h0, 64'(ch_u.wp));
		rd(REG_CTRL, d);
		chk("ctrl readback", 64'({sb, wo, 1'b0}), 64'(d[2:0]));
	endtask : fmt_sector
	// loop the captured sector back and judge the parsed result
	task automatic parse_sector(input logic b, input logic c, input logic wo, input logic sb);
		logic [7:0] d;
		@(posedge clock_i) {replay, bad, cut} <= {1'b1, b, c};
		@(posedge clock_i) replay <= 1'b0;
		for (int k = 0; k < 9000 && rx_done_o !== 1'b1; k++) @(negedge clock_i);
		chk("done pulse", 64'h1, 64'(rx_done_o));
		chk("header valid", 64'(!(b || c)), 64'(hdr_valid_o));
		rd(REG_STATUS, d);
		chk("invalid flag", 64'(b || c), 64'(d[STS_INV]));
		chk("length flag", 64'(c), 64'(d[STS_LEN]));
		if (b || c) begin
			// write one to clear the sticky verdict
			wr(REG_STATUS, 8'h1e);
			rd(REG_STATUS, d);
			chk("flags cleared", 64'h0, 64'(d[4:1]));
		end else begin
			chk("serial", 64'(SER), 64'(rx_serial_o));
			chk("side", 64'(sb ? 4'hb : 4'ha), 64'(rx_side_o));
			chk("media", 64'(wo), 64'(rx_wo_o));
			chk("recorder", 64'(REC), 64'(rx_rec_o));
			rd(HDR_BASE + 8'h07, d);
			chk("parsed rev", 64'h5a, 64'(d));
		end
	endtask : parse_sector
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// hang guard well above two sectors plus four replays
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		logic [7:0] d;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		rd(REG_REV, d);
		chk("rev reset", 64'h00, 64'(d));
		rd(8'h30, d);
		chk("unmapped read", 64'h00, 64'(d));
		wr(REG_REV, 8'h5a);
		fmt_sector(1'b0, 1'b0);
		parse_sector(1'b0, 1'b0, 1'b0, 1'b0);
		slow <= 1'b1;
		fmt_sector(1'b1, 1'b1);
		slow <= 1'b0;
		parse_sector(1'b0, 1'b0, 1'b1, 1'b1);
		parse_sector(1'b1, 1'b0, 1'b1, 1'b1);
		parse_sector(1'b0, 1'b1, 1'b1, 1'b1);
		wrap_up();
	end
endmodule : disk_info_sector_formatter_bench
